// [common/alu_pkg.sv]
// constants, field layouts and opcodes of the accumulator datapath
package alu_pkg;

  localparam int DATA_W     = 8;
  localparam int REG_ADDR_W = 7;
  localparam int NUM_REGS   = 128;
  localparam int HADDR_W    = 12;
  localparam int F_ADDR_W   = 4;
  localparam int F_SLOTS    = 11;

  // register byte offsets on the bus
  localparam logic [HADDR_W-1:0] OFS_INSTR  = 12'h000;
  localparam logic [HADDR_W-1:0] OFS_WREG   = 12'h004;
  localparam logic [HADDR_W-1:0] OFS_STATUS = 12'h008;
  localparam logic [HADDR_W-1:0] OFS_FPAGE  = 12'h100;
  localparam logic [HADDR_W-1:0] OFS_DPAGE  = 12'h200;
  localparam logic [HADDR_W-1:0] WIN_MASK   = 12'hF00;
  localparam logic [HADDR_W-1:0] DPAGE_MASK = 12'hE00;

  // f-page window limits
  localparam logic [F_ADDR_W-1:0] FPAGE_LO = 4'h5;
  localparam logic [F_ADDR_W-1:0] FPAGE_HI = 4'hF;

  // instruction word field positions
  localparam int INSTR_OP_LSB   = 0;
  localparam int INSTR_OP_W     = 4;
  localparam int INSTR_DEST_BIT = 4;
  localparam int INSTR_BIT_LSB  = 5;
  localparam int INSTR_IMM_LSB  = 8;
  localparam int INSTR_REG_LSB  = 16;
  localparam int INSTR_F_LSB    = 24;

  // status word bit positions
  localparam int ST_C    = 0;
  localparam int ST_DC   = 1;
  localparam int ST_Z    = 2;
  localparam int ST_PD   = 3;
  localparam int ST_TO   = 4;
  localparam int ST_FERR = 5;

  // values after reset
  localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
  localparam logic              PD_RST   = 1'b1;
  localparam logic              TO_RST   = 1'b1;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [INSTR_OP_W-1:0] {
    OP_NOP                = 4'h0,
    OP_ADD_REG_WITH_CARRY = 4'h1,
    OP_ADD_REG_PLAIN      = 4'h2,
    OP_ADD_IMM_WITH_CARRY = 4'h3,
    OP_ADD_IMM_PLAIN      = 4'h4,
    OP_BITWISE_CONJ_REG   = 4'h5,
    OP_BIT_ZEROING        = 4'h6,
    OP_WATCHDOG_KICK      = 4'h7,
    OP_HALT_ENTRY         = 4'h8,
    OP_FPAGE_LOAD         = 4'h9
  } op_t;

endpackage

// [hdl/alu_adder8.sv]
// adder with carry out and carry out of the low nibble
`timescale 1ns/1ps
`default_nettype none
module alu_adder8 #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  output logic      [W-1:0] sum,
  output logic              carry,
  output logic              half_carry
);
  logic [W:0]   full;
  logic [4:0]   low;

  always_comb begin
    full       = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    low        = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    sum        = full[W-1:0];
    carry      = full[W];
    half_carry = low[4];
  end
endmodule
`default_nettype wire

// [hdl/alu_status_flags.sv]
// power-down and time-out status flags
`timescale 1ns/1ps
`default_nettype none
module alu_status_flags
  import alu_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic kick,
  input  wire logic halt,
  input  wire logic timeout,
  output logic      pd,
  output logic      to,
  output logic      pd_next,
  output logic      to_next,
  output logic      watchdog_kick
);
  typedef struct packed {
    logic pd;
    logic to;
    logic kick;
  } flags_t;

  flags_t st;
  flags_t next_st;

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.kick = kick;
      if (halt) begin
        next_st.pd = 1'b0;
      end
      if (kick) begin
        next_st.pd = 1'b1;
      end
      if (timeout) begin
        next_st.to = 1'b0;
      end
      // the set wins when an instruction meets a timeout in one cycle
      if (kick || halt) begin
        next_st.to = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= '{pd: PD_RST, to: TO_RST, kick: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pd            = st.pd;
  assign to            = st.to;
  assign pd_next       = next_st.pd;
  assign to_next       = next_st.to;
  assign watchdog_kick = st.kick;
endmodule
`default_nettype wire

// [hdl/mcu_alu_flag_datapath.sv]
// accumulator datapath with flag logic behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - carry is set by a carry out of an addition and cleared when there is none.
// - destination bit 0 writes the working register, 1 writes the addressed register.
// - power-down flag is 1 after reset and after a watchdog kick, 0 after halt entry.
// - time-out flag is 1 after reset and after a watchdog kick or halt entry.
// - time-out flag clears when the watchdog counter times out.
// - the register operand is a 7-bit address covering 0x0 to 0x7F.
// - f-page transfers only reach addresses 0x5 to 0xF.
// - add register with carry sums working register, register and carry, sets Z DC C in one cycle.
// - add register sums working register and register, routes by destination, sets Z DC C in one cycle.
// - add immediate with carry sums working register, immediate and carry into the working register.
// - add immediate sums working register and immediate into the working register, sets Z DC C.
// - and register combines working register and register, routes by destination, sets only Z.
// - bit clear zeroes one bit 0 to 7 of the register and leaves all flags alone, in one cycle.
module mcu_alu_flag_datapath
  import alu_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [HADDR_W-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [31:0]        hrdata,
  input  wire logic               watchdog_timeout,
  output logic                    watchdog_kick,
  output logic                    halt_entry,
  output logic      [DATA_W-1:0]  working_register,
  output logic                    power_down_status_flag,
  output logic                    time_out_status_flag
);

  typedef struct packed {
    logic [DATA_W-1:0]                wreg;
    logic                             c;
    logic                             dc;
    logic                             z;
    logic                             ferr;
    logic                             halt;
    logic [NUM_REGS-1:0][DATA_W-1:0]  page;
    logic [F_SLOTS-1:0][DATA_W-1:0]   fpage;
    logic                             ph_wr;
    logic [HADDR_W-1:0]               ph_addr;
    logic [31:0]                      rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // one byte zero-extended into a bus word
  function automatic logic [31:0] word_of(input logic [DATA_W-1:0] b);
    word_of = {24'h000000, b};
  endfunction

  function automatic logic fpage_ok(input logic [F_ADDR_W-1:0] f);
    fpage_ok = (f >= FPAGE_LO) && (f <= FPAGE_HI);
  endfunction

  function automatic logic [3:0] fpage_slot(input logic [F_ADDR_W-1:0] f);
    fpage_slot = f - FPAGE_LO;
  endfunction

  logic                    addr_phase;
  logic                    instr_wr;
  op_t                     op;
  logic [REG_ADDR_W-1:0]   ra;
  logic [DATA_W-1:0]       imm;
  logic [2:0]              bsel;
  logic                    dsel;
  logic [F_ADDR_W-1:0]     fa;
  logic [DATA_W-1:0]       opnd_r;
  logic [DATA_W-1:0]       add_b;
  logic                    add_cin;
  logic [DATA_W-1:0]       add_sum;
  logic                    add_c;
  logic                    add_dc;
  logic [DATA_W-1:0]       and_res;
  logic                    kick;
  logic                    halt;
  logic                    pd;
  logic                    to;
  logic                    pd_next;
  logic                    to_next;

  assign addr_phase = ce && hsel && hready && htrans[1];
  assign instr_wr   = ce && st.ph_wr && (st.ph_addr == OFS_INSTR);

  // instruction fields, taken straight from the data phase
  assign op      = op_t'(hwdata[INSTR_OP_LSB +: INSTR_OP_W]);
  assign ra      = hwdata[INSTR_REG_LSB +: REG_ADDR_W];
  assign imm     = hwdata[INSTR_IMM_LSB +: DATA_W];
  assign bsel    = hwdata[INSTR_BIT_LSB +: 3];
  assign dsel    = hwdata[INSTR_DEST_BIT];
  assign fa      = hwdata[INSTR_F_LSB +: F_ADDR_W];
  assign opnd_r  = st.page[ra];

  assign add_b   = ((op == OP_ADD_IMM_WITH_CARRY) || (op == OP_ADD_IMM_PLAIN)) ? imm : opnd_r;
  // the plain adds never read the carry flag
  assign add_cin = ((op == OP_ADD_REG_WITH_CARRY) || (op == OP_ADD_IMM_WITH_CARRY)) ? st.c : 1'b0;
  assign and_res = st.wreg & opnd_r;

  assign kick    = instr_wr && (op == OP_WATCHDOG_KICK);
  assign halt    = instr_wr && (op == OP_HALT_ENTRY);

  alu_adder8 #(
    .W          (DATA_W)
  ) u_adder (
    .a          (st.wreg),
    .b          (add_b),
    .cin        (add_cin),
    .sum        (add_sum),
    .carry      (add_c),
    .half_carry (add_dc)
  );

  alu_status_flags u_flags (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .ce            (ce),
    .kick          (kick),
    .halt          (halt),
    .timeout       (watchdog_timeout),
    .pd            (pd),
    .to            (to),
    .pd_next       (pd_next),
    .to_next       (to_next),
    .watchdog_kick (watchdog_kick)
  );

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.halt = halt;

      // data phase of a write
      if (st.ph_wr) begin
        if (st.ph_addr == OFS_WREG) begin
          next_st.wreg = hwdata[DATA_W-1:0];
        end else if (st.ph_addr == OFS_STATUS) begin
          next_st.c  = hwdata[ST_C];
          next_st.dc = hwdata[ST_DC];
          next_st.z  = hwdata[ST_Z];
          if (hwdata[ST_FERR]) begin
            next_st.ferr = 1'b0;
          end
        end else if ((st.ph_addr & DPAGE_MASK) == OFS_DPAGE) begin
          next_st.page[st.ph_addr[8:2]] = hwdata[DATA_W-1:0];
        end else if ((st.ph_addr & WIN_MASK) == OFS_FPAGE) begin
          if (fpage_ok(st.ph_addr[5:2])) begin
            next_st.fpage[fpage_slot(st.ph_addr[5:2])] = hwdata[DATA_W-1:0];
          end
        end
      end

      // executing an instruction written to the instruction register
      if (instr_wr) begin
        case (op)
          OP_ADD_REG_WITH_CARRY,
          OP_ADD_REG_PLAIN: begin
            if (dsel) begin
              next_st.page[ra] = add_sum;
            end else begin
              next_st.wreg = add_sum;
            end
            next_st.c  = add_c;
            next_st.dc = add_dc;
            next_st.z  = (add_sum == '0);
          end
          OP_ADD_IMM_WITH_CARRY,
          OP_ADD_IMM_PLAIN: begin
            next_st.wreg = add_sum;
            next_st.c    = add_c;
            next_st.dc   = add_dc;
            next_st.z    = (add_sum == '0);
          end
          OP_BITWISE_CONJ_REG: begin
            if (dsel) begin
              next_st.page[ra] = and_res;
            end else begin
              next_st.wreg = and_res;
            end
            next_st.z = (and_res == '0);
          end
          OP_BIT_ZEROING: begin
            next_st.page[ra][bsel] = 1'b0;
          end
          OP_FPAGE_LOAD: begin
            // an address outside the window stores nothing and flags it
            if (fpage_ok(fa)) begin
              next_st.fpage[fpage_slot(fa)] = st.wreg;
            end else begin
              next_st.ferr = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end

      // address phase; reads see the state as it stands after this cycle
      next_st.ph_wr   = addr_phase && hwrite && (hsize == HSIZE_WORD);
      next_st.ph_addr = haddr;
      if (addr_phase && !hwrite) begin
        if (haddr == OFS_WREG) begin
          next_st.rdata = word_of(next_st.wreg);
        end else if (haddr == OFS_STATUS) begin
          next_st.rdata = 32'h00000000;
          next_st.rdata[ST_C]    = next_st.c;
          next_st.rdata[ST_DC]   = next_st.dc;
          next_st.rdata[ST_Z]    = next_st.z;
          next_st.rdata[ST_PD]   = pd_next;
          next_st.rdata[ST_TO]   = to_next;
          next_st.rdata[ST_FERR] = next_st.ferr;
        end else if ((haddr & DPAGE_MASK) == OFS_DPAGE) begin
          next_st.rdata = word_of(next_st.page[haddr[8:2]]);
        end else if (((haddr & WIN_MASK) == OFS_FPAGE) && fpage_ok(haddr[5:2])) begin
          next_st.rdata = word_of(next_st.fpage[fpage_slot(haddr[5:2])]);
        end else begin
          next_st.rdata = 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // zero-wait slave; a low clock enable stretches every phase
  assign hreadyout              = ce;
  assign hresp                  = 1'b0;
  assign hrdata                 = st.rdata;
  assign halt_entry             = st.halt;
  assign working_register       = st.wreg;
  assign power_down_status_flag = pd;
  assign time_out_status_flag   = to;

endmodule
`default_nettype wire

// [verif/mcu_alu_flag_monitor.sv]
// flag pin assertions for the datapath
`timescale 1ns/1ps
`default_nettype none
module mcu_alu_flag_monitor (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic watchdog_timeout,
  input wire logic watchdog_kick,
  input wire logic halt_entry,
  input wire logic power_down_status_flag,
  input wire logic time_out_status_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // a kick or halt in the same cycle outranks the timeout
  sequence s_lone_timeout;
    (watchdog_timeout && ce) ##1 (!watchdog_kick && !halt_entry);
  endsequence
  sequence s_fresh_rise_pd;
    $rose(power_down_status_flag) && $past(resetn);
  endsequence
  sequence s_fresh_rise_to;
    $rose(time_out_status_flag) && $past(resetn);
  endsequence
  property p_pd_halt; halt_entry |-> !power_down_status_flag; endproperty
  property p_pd_kick; watchdog_kick |-> power_down_status_flag; endproperty
  property p_to_kick; watchdog_kick |-> time_out_status_flag; endproperty
  property p_to_halt; halt_entry |-> time_out_status_flag; endproperty
  property p_to_clear; s_lone_timeout |-> !time_out_status_flag; endproperty
  property p_to_rise; s_fresh_rise_to |-> (watchdog_kick || halt_entry); endproperty
  property p_pd_fall; $fell(power_down_status_flag) |-> halt_entry; endproperty
  property p_pd_rise; s_fresh_rise_pd |-> watchdog_kick; endproperty
  a_pd_halt: assert property (p_pd_halt)
    else $error("pd high after halt");
  a_pd_kick: assert property (p_pd_kick)
    else $error("pd low after kick");
  a_to_kick: assert property (p_to_kick)
    else $error("to low after kick");
  a_to_halt: assert property (p_to_halt)
    else $error("to low after halt");
  a_to_clear: assert property (p_to_clear)
    else $error("to kept after timeout");
  a_to_rise: assert property (p_to_rise)
    else $error("to rose without cause");
  a_pd_fall: assert property (p_pd_fall)
    else $error("pd fell without halt");
  a_pd_rise: assert property (p_pd_rise)
    else $error("pd rose without kick");
endmodule
bind mcu_alu_flag_datapath mcu_alu_flag_monitor i_mon (
  .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .watchdog_timeout(watchdog_timeout),
  .watchdog_kick(watchdog_kick), .halt_entry(halt_entry),
  .power_down_status_flag(power_down_status_flag), .time_out_status_flag(time_out_status_flag));
`default_nettype wire

// [verif/mcu_alu_flag_datapath_tb.sv]
// self-checking bench for the accumulator datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module mcu_alu_flag_datapath_tb;
  import alu_pkg::*;
  logic               clk_sys = 1'b0;
  logic               resetn = 1'b0;
  logic               ce = 1'b1;
  logic               hsel = 1'b0;
  logic [HADDR_W-1:0] haddr = '0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = HSIZE_WORD;
  logic [31:0]        hwdata = 32'h0;
  logic               watchdog_timeout = 1'b0;
  logic [31:0]        rv;
  int                 fail_count = 0;
  int                 samples_checked = 0;
  wire logic hreadyout, hresp, watchdog_kick, halt_entry, power_down_status_flag, time_out_status_flag;
  wire logic [31:0] hrdata;
  wire logic [DATA_W-1:0] working_register;
  always #20 clk_sys = ~clk_sys;
  mcu_alu_flag_datapath i_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .watchdog_timeout(watchdog_timeout), .watchdog_kick(watchdog_kick), .halt_entry(halt_entry),
    .working_register(working_register), .power_down_status_flag(power_down_status_flag),
    .time_out_status_flag(time_out_status_flag));
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded, so a stuck hreadyout ends the run instead of hanging it
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      `CHK("hreadyout", 1'b1, hreadyout)
      close_out();
    end
  endtask
  task automatic bus(input logic wr, input logic [HADDR_W-1:0] a, input logic [31:0] d);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    rv = hrdata;
  endtask
  task automatic chk_rd(input string nm, input logic [HADDR_W-1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rv)
  endtask
  task automatic ex(input int op, input int d, input int b, input int imm, input int r, input int f);
    bus(1'b1, OFS_INSTR, {4'h0, f[3:0], 1'b0, r[6:0], imm[7:0], b[2:0], d[0], op[3:0]});
  endtask
  function automatic logic [HADDR_W-1:0] pa(input int r);
    return OFS_DPAGE + HADDR_W'(r * 4);
  endfunction
  task automatic pins(input logic pd, input logic to, input logic kick, input logic halt);
    #1;
    `CHK("pd pin", pd, power_down_status_flag)
    `CHK("to pin", to, time_out_status_flag)
    `CHK("kick pin", kick, watchdog_kick)
    `CHK("halt pin", halt, halt_entry)
    @(posedge clk_sys);
  endtask
  task automatic t_reset();
    `CHK("pd reset", 1'b1, power_down_status_flag)
    `CHK("to reset", 1'b1, time_out_status_flag)
    chk_rd("status reset", OFS_STATUS, 32'h18);
  endtask
  task automatic t_add();
    logic [7:0] av [3];
    logic [7:0] bv [3];
    logic [7:0] pv;
    logic [8:0] s;
    logic       c;
    logic       cin;
    logic       hc;
    logic       to_w;
    int         r;
    av = '{8'h12, 8'hFF, 8'h08};
    bv = '{8'h34, 8'h01, 8'h08};
    for (int op = 1; op <= 4; op++) begin
      for (int k = 0; k < 6; k++) begin
        r = k[0] ? 127 : k;
        cin = ~k[0];
        c = (op == 1 || op == 3) ? cin : 1'b0;
        s = av[k % 3] + bv[k % 3] + c;
        hc = ({1'b0, av[k % 3][3:0]} + bv[k % 3][3:0] + c) > 5'hF;
        to_w = (op >= 3) || (k < 3);
        // the unused operand holds the complement so a wrong mux shows up
        pv = (op >= 3) ? ~bv[k % 3] : bv[k % 3];
        bus(1'b1, OFS_WREG, {24'h0, av[k % 3]});
        bus(1'b1, pa(r), {24'h0, pv});
        bus(1'b1, OFS_STATUS, {31'h0, cin});
        ex(op, k / 3, 0, (op >= 3) ? bv[k % 3] : ~bv[k % 3], r, 0);
        chk_rd("sum acc", OFS_WREG, {24'h0, to_w ? s[7:0] : av[k % 3]});
        `CHK("acc pin", to_w ? s[7:0] : av[k % 3], working_register)
        chk_rd("sum reg", pa(r), {24'h0, to_w ? pv : s[7:0]});
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK("sum flags", {s[7:0] == 8'h0, hc, s[8]}, rv[2:0])
      end
    end
  endtask
  task automatic t_and();
    bus(1'b1, OFS_STATUS, 32'h3);
    bus(1'b1, OFS_WREG, 32'h5A);
    bus(1'b1, pa(9), 32'hAF);
    ex(5, 1, 0, 0, 9, 0);
    chk_rd("and reg", pa(9), 32'h0A);
    chk_rd("and acc", OFS_WREG, 32'h5A);
    chk_rd("and flags", OFS_STATUS, 32'h1B);
    bus(1'b1, pa(9), 32'hA5);
    ex(5, 0, 0, 0, 9, 0);
    chk_rd("and zero", OFS_WREG, 32'h0);
    chk_rd("and z flag", OFS_STATUS, 32'h1F);
  endtask
  task automatic t_bitclr();
    bus(1'b1, OFS_STATUS, 32'h5);
    for (int b = 0; b < 8; b++) begin
      bus(1'b1, pa(100 + b), 32'hFF);
      ex(6, 0, b, 0, 100 + b, 0);
      chk_rd("bit clear", pa(100 + b), 32'hFF & ~(32'h1 << b));
    end
    chk_rd("bit clear flags", OFS_STATUS, 32'h1D);
  endtask
  task automatic t_fpage();
    bus(1'b1, OFS_WREG, 32'hA5);
    ex(9, 0, 0, 0, 0, 4);
    chk_rd("f slot 4", OFS_FPAGE + 12'h10, 32'h0);
    chk_rd("f error", OFS_STATUS, 32'h3D);
    bus(1'b1, OFS_STATUS, 32'h25);
    for (int f = 5; f <= 15; f += 10) begin
      ex(9, 0, 0, 0, 0, f);
      chk_rd("f slot", OFS_FPAGE + HADDR_W'(f * 4), 32'hA5);
    end
    chk_rd("f no error", OFS_STATUS, 32'h1D);
  endtask
  task automatic tmo();
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    watchdog_timeout <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_flags();
    ce <= 1'b0;
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    ce <= 1'b1;
    watchdog_timeout <= 1'b0;
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    tmo();
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    ex(8, 0, 0, 0, 0, 0);
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    tmo();
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    ex(7, 0, 0, 0, 0, 0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_add();
    t_and();
    t_bitclr();
    t_fpage();
    t_flags();
    close_out();
  end
endmodule
`default_nettype wire
